//--- rtl/epc_map.svh
/*
 Offsets, field positions, reset values and codes for the programming control block.
 Assumes inclusion by bare name; definitions only.
*/
`ifndef EPC_MAP_SVH
`define EPC_MAP_SVH
`define EPC_ADDR_UNLOCK 8'h91
`define EPC_ADDR_BIAS 8'hA2
`define EPC_ADDR_VGEN 8'hF3
`define EPC_UNLOCK_CODE 6'h3B
`define EPC_UNLOCK_RST 6'h00
`define EPC_BIAS_RST 1'b0
`define EPC_VGEN_RST 8'h00
`define EPC_BIT_PWR 7
`define EPC_BIT_PUMPCK 6
`define EPC_UPPER_LO 6'h10
`define EPC_UPPER_HI 6'h27
`endif

//--- rtl/epc_pkg.sv
/*
 Types for the programming control block.
 Assumes nothing of its surroundings.
*/
package epc_pkg;
    typedef logic [5:0] epc_addr_t;
    typedef logic [7:0] epc_byte_t;
endpackage

//--- rtl/epc_guard.sv
/*
 Protection check for one programming request address.
 Assumes the unlock field is held in a register by the caller.
*/
`include "epc_map.svh"
module epc_guard (
    input wire logic [5:0] unlock_code_field,
    input wire logic [5:0] req_addr,
    output logic upper_hit,
    output logic allowed
);
    always_comb begin
        upper_hit = (req_addr >= `EPC_UPPER_LO) && (req_addr <= `EPC_UPPER_HI);
        allowed = !upper_hit || (unlock_code_field == `EPC_UNLOCK_CODE);
    end
endmodule

//--- rtl/epc_top.sv
/*
 Nonvolatile programming control registers on the extended special register bus.
 Assumes a synchronous byte write strobe from the core and one 100 MHz clock.
*/
`include "epc_map.svh"
module epc_top (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic timer_rst,
    input wire logic reg_we,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic prog_req,
    input wire logic [5:0] prog_addr,
    output logic prog_grant,
    output logic prog_refused,
    output logic bias_power_bit,
    output logic rf_detector_power,
    output logic generator_power_bit,
    output logic pump_clock_select,
    output logic [5:0] generator_level_field,
    output logic [7:0] antenna_tuning_ctrl
);
    logic rst_s1_q;
    logic rst_s2_q;
    logic rst_n;
    logic [5:0] unlock_q;
    logic bias_q;
    epc_pkg::epc_byte_t vgen_q;
    logic allowed;
    logic upper_hit;
    logic wr_unlock;
    logic wr_bias;
    logic wr_vgen;

    // Reset release through two stages
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    assign rst_n = rst_s2_q;

    // One write decode per mapped address; others dropped
    always_comb begin
        wr_unlock = reg_we && (reg_addr == `EPC_ADDR_UNLOCK);
        wr_bias = reg_we && (reg_addr == `EPC_ADDR_BIAS);
        wr_vgen = reg_we && (reg_addr == `EPC_ADDR_VGEN);
    end

    // Unlock vector cleared by power-on and timer reset
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            unlock_q <= `EPC_UNLOCK_RST;
        end else if (timer_rst) begin
            unlock_q <= `EPC_UNLOCK_RST;
        end else if (wr_unlock) begin
            unlock_q <= reg_wdata[5:0];
        end
    end

    // Bias bit keeps its value over timer reset
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bias_q <= `EPC_BIAS_RST;
        end else if (wr_bias) begin
            bias_q <= reg_wdata[`EPC_BIT_PWR];
        end
    end

    // Generator control keeps its value over timer reset
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            vgen_q <= `EPC_VGEN_RST;
        end else if (wr_vgen) begin
            vgen_q <= reg_wdata;
        end
    end

    assign bias_power_bit = bias_q;
    assign rf_detector_power = bias_q;
    assign generator_power_bit = vgen_q[`EPC_BIT_PWR];
    assign pump_clock_select = vgen_q[`EPC_BIT_PUMPCK];
    assign generator_level_field = vgen_q[5:0];
    assign antenna_tuning_ctrl = vgen_q;

    epc_guard u_guard (
        .unlock_code_field(unlock_q),
        .req_addr(prog_addr),
        .upper_hit(upper_hit),
        .allowed(allowed)
    );

    // Grant combinational with the request
    assign prog_grant = prog_req && allowed;
    assign prog_refused = prog_req && !allowed;

    // Request protection checks
    a_upper_locked: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (prog_req && upper_hit && unlock_q != `EPC_UNLOCK_CODE) |-> !prog_grant && prog_refused
    ) else $error("locked upper request granted");
    a_upper_open: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (prog_req && unlock_q == `EPC_UNLOCK_CODE) |-> prog_grant
    ) else $error("unlocked request not granted");
    a_lower_open: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (prog_req && !upper_hit) |-> prog_grant && !prog_refused
    ) else $error("lower request not granted");
    a_grant_excl: assert property (
        @(posedge mclk) disable iff (!rst_n)
        prog_req |-> prog_grant != prog_refused
    ) else $error("grant and refusal not exclusive");
    a_req_idle: assert property (
        @(posedge mclk) disable iff (!rst_n)
        !prog_req |-> !prog_grant && !prog_refused
    ) else $error("answer without request");
    a_refuse_cause: assert property (
        @(posedge mclk) disable iff (!rst_n)
        prog_refused |-> upper_hit && unlock_q != `EPC_UNLOCK_CODE
    ) else $error("request refused without lock");

    // Unlock register checks
    a_unlock_write: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (wr_unlock && !timer_rst) |=> unlock_q == $past(reg_wdata[5:0])
    ) else $error("unlock write lost");
    a_unlock_timer: assert property (
        @(posedge mclk) disable iff (!rst_n)
        timer_rst |=> unlock_q == `EPC_UNLOCK_RST
    ) else $error("unlock not cleared by timer reset");
    a_unlock_hold: assert property (
        @(posedge mclk) disable iff (!rst_n)
        !(wr_unlock || timer_rst) |=> $stable(unlock_q)
    ) else $error("unlock changed without write");

    // Bias register checks
    a_bias_write: assert property (
        @(posedge mclk) disable iff (!rst_n)
        wr_bias |=> bias_power_bit == $past(reg_wdata[`EPC_BIT_PWR])
    ) else $error("bias bit not updated");
    a_bias_hold: assert property (
        @(posedge mclk) disable iff (!rst_n)
        !wr_bias |=> $stable(bias_power_bit)
    ) else $error("bias bit changed without write");
    a_bias_shared: assert property (
        @(posedge mclk) disable iff (!rst_n)
        rf_detector_power == bias_power_bit
    ) else $error("bias and detector power differ");
    a_detector_write: assert property (
        @(posedge mclk) disable iff (!rst_n)
        wr_bias |=> rf_detector_power == $past(reg_wdata[`EPC_BIT_PWR])
    ) else $error("detector power not updated");

    // Generator register checks
    a_gen_write: assert property (
        @(posedge mclk) disable iff (!rst_n)
        wr_vgen |=> generator_power_bit == $past(reg_wdata[`EPC_BIT_PWR])
        && generator_level_field == $past(reg_wdata[5:0])
    ) else $error("generator control not updated");
    a_gen_power_hold: assert property (
        @(posedge mclk) disable iff (!rst_n)
        !wr_vgen |=> $stable(generator_power_bit)
    ) else $error("generator power changed without write");
    a_gen_hold: assert property (
        @(posedge mclk) disable iff (!rst_n)
        !wr_vgen |=> $stable(generator_level_field)
    ) else $error("level changed without write");
    a_gen_shared: assert property (
        @(posedge mclk) disable iff (!rst_n)
        antenna_tuning_ctrl == {generator_power_bit, pump_clock_select, generator_level_field}
    ) else $error("tuning and generator bits differ");
    a_tuning_write: assert property (
        @(posedge mclk) disable iff (!rst_n)
        wr_vgen |=> antenna_tuning_ctrl == $past(reg_wdata)
    ) else $error("tuning control not updated");
    a_pump_write: assert property (
        @(posedge mclk) disable iff (!rst_n)
        wr_vgen |=> pump_clock_select == $past(reg_wdata[`EPC_BIT_PUMPCK])
    ) else $error("pump select not updated");
    a_tuning_hold: assert property (
        @(posedge mclk) disable iff (!rst_n)
        !wr_vgen |=> $stable(antenna_tuning_ctrl)
    ) else $error("tuning changed without write");
endmodule

//--- tb/epc_top_tb.sv
/*
 Self-checking bench for epc_top: register writes and upper region protection.
 Assumes the rtl files are compiled first and a 100 MHz clock.
*/
module epc_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 0, rstn = 0, timer_rst = 0, reg_we = 0, prog_req = 0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
    logic [5:0] prog_addr = 6'h00;
    logic prog_grant, prog_refused, bias_power_bit, rf_detector_power, generator_power_bit, pump_clock_select;
    logic [5:0] generator_level_field;
    logic [7:0] antenna_tuning_ctrl;
    int failures = 0, checked = 0;
    always #5 mclk = ~mclk;
    epc_top uut (.mclk, .rstn, .timer_rst, .reg_we, .reg_addr, .reg_wdata, .prog_req, .prog_addr,
        .prog_grant, .prog_refused, .bias_power_bit, .rf_detector_power, .generator_power_bit,
        .pump_clock_select, .generator_level_field, .antenna_tuning_ctrl);
    task automatic final_report;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        #1 reg_we = 1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge mclk);
        #1 reg_we = 0;
    endtask
    task automatic pr(input logic [5:0] a, input logic [1:0] e);
        @(posedge mclk);
        #1 prog_addr = a;
        prog_req = 1;
        @(negedge mclk);
        chk({6'h00, prog_grant, prog_refused}, {6'h00, e});
    endtask
    // Boundaries of the protected region, locked or open
    task automatic sweep(input logic lk);
        pr(6'h0F, 2'b10);
        pr(6'h10, lk ? 2'b01 : 2'b10);
        pr(6'h27, lk ? 2'b01 : 2'b10);
        pr(6'h28, 2'b10);
    endtask
    task automatic rs(input logic b, input logic [7:0] g);
        chk({bias_power_bit, rf_detector_power, 6'h00}, {b, b, 6'h00});
        chk({generator_power_bit, pump_clock_select, generator_level_field}, g);
        chk(antenna_tuning_ctrl, g);
    endtask
    task automatic por;
        rstn = 0;
        repeat (5) @(posedge mclk);
        #1 rstn = 1;
        repeat (3) @(posedge mclk);
        #1;
    endtask
    initial begin
        #20000;
        failures++;
        final_report;
    end
    initial begin
        por;
        rs(1'b0, 8'h00);
        sweep(1'b1);
        pr(6'h02, 2'b10);
        wr(8'h91, 8'h3A);
        sweep(1'b1);
        wr(8'h91, 8'h3B);
        sweep(1'b0);
        wr(8'hA2, 8'h80);
        wr(8'hF3, 8'hC0);
        rs(1'b1, 8'hC0);
        wr(8'hF3, 8'hD7);
        rs(1'b1, 8'hD7);
        repeat (64) @(posedge mclk);
        #1 rs(1'b1, 8'hD7);
        wr(8'h92, 8'h00);
        rs(1'b1, 8'hD7);
        @(posedge mclk);
        #1 timer_rst = 1;
        @(posedge mclk);
        #1 timer_rst = 0;
        sweep(1'b1);
        rs(1'b1, 8'hD7);
        wr(8'h91, 8'h3B);
        timer_rst = 1;
        wr(8'h91, 8'h3B);
        timer_rst = 0;
        sweep(1'b1);
        wr(8'hF3, 8'h00);
        wr(8'hA2, 8'h00);
        rs(1'b0, 8'h00);
        wr(8'h91, 8'h3B);
        wr(8'hF3, 8'hD7);
        por;
        rs(1'b0, 8'h00);
        sweep(1'b1);
        final_report;
    end
endmodule
